// >>> core/slot_assign_pkg.sv
// Constants shared by the PCM time-slot assigner and its slot timers
// What this block does
// - Swap high: transmit enable from transmit sync; low: enables cross over
// - Bit clock divided by eight forms the slot boundaries on both sides
// - Transmit sync clears bit and slot counters; next slot is slot zero
// - Transmit enable starts and ends on eight-bit word boundaries
// - Receive sync does the same for receive side; any offset allowed
// - Each enable rises at slot start, falls at end, eight bit periods
// - Channel pulse is strobe gate ANDed with the transmit slot period
// - No two channels in a bank share a transmit slot number
// - Six-bit slot number counts slots after frame sync, bit 0 lowest
// - Hold high passes slot word through; low captures and keeps it
package slot_assign_pkg;
	// Clock rates
	localparam int unsigned SYS_CLK_HZ     = 20_000_000;
	localparam int unsigned BIT_CLK_MAX_HZ = 2_560_000;
	// Least system cycles per bit period at the fastest bit clock
	localparam int unsigned BIT_PERIOD_MIN_CYC = SYS_CLK_HZ / BIT_CLK_MAX_HZ;
	// Counter widths and wrap points
	localparam int unsigned BIT_CNT_W = 3;
	localparam int unsigned SLOT_W    = 6;
	localparam logic [2:0]  BIT_LAST  = 3'h7;
	// Register byte offsets
	localparam logic [7:0]  CTRL_OFS   = 8'h00;
	localparam logic [7:0]  STATUS_OFS = 8'h04;
	localparam int unsigned ADDR_W     = 8;
	// Control field positions
	localparam int unsigned CTRL_SLOT_LSB = 0;
	localparam int unsigned CTRL_SWAP_BIT = 8;
	localparam int unsigned CTRL_HOLD_BIT = 9;
	localparam int unsigned CTRL_GATE_BIT = 10;
	// Control reset: swap, hold and gate high as if pulled up
	localparam logic [31:0] CTRL_RESET = 32'h0000_0700;
	// Status field positions
	localparam int unsigned STAT_TXCNT_LSB = 8;
	localparam int unsigned STAT_RXCNT_LSB = 16;
	localparam int unsigned STAT_TXEN_BIT  = 24;
	localparam int unsigned STAT_RXEN_BIT  = 25;
	localparam int unsigned STAT_PULSE_BIT = 26;
	localparam int unsigned STAT_SWAP_BIT  = 27;
	// Bus encodings
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage

// >>> core/slot_timer.sv
// One slot timer: bit and slot counters reset by a frame sync
`timescale 1ns/10ps
module slot_timer
	import slot_assign_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset_n,
	input  wire logic              bit_edge,
	input  wire logic              frame_sync,
	input  wire logic [SLOT_W-1:0] slot_sel,
	output logic                   slot_enable_r,
	output logic [SLOT_W-1:0]      slot_cnt_r
);
	logic [BIT_CNT_W-1:0] bit_cnt_r;
	logic                 framed_r;
	logic [SLOT_W-1:0]    slot_nxt;

	// Slot that starts at this bit edge
	always_comb
	begin
		if (frame_sync)
			slot_nxt = '0;
		else if (bit_cnt_r == BIT_LAST)
			slot_nxt = slot_cnt_r + 6'h01;
		else
			slot_nxt = slot_cnt_r;
	end

	// Divide-by-eight bit counter, cleared by the sync
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			bit_cnt_r <= '0;
		else if (bit_edge)
			bit_cnt_r <= frame_sync ? '0 : bit_cnt_r + 3'h1;
	end

	// Slot counter wraps at 64 by its own width
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			slot_cnt_r <= '0;
		else if (bit_edge)
			slot_cnt_r <= slot_nxt;
	end

	// No enable before the first sync: slot position is unknown
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			framed_r <= 1'b0;
		else if (bit_edge && frame_sync)
			framed_r <= 1'b1;
	end

	// Enable changes only at word boundaries, so it lasts eight bits
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			slot_enable_r <= 1'b0;
		else if (bit_edge && (frame_sync || bit_cnt_r == BIT_LAST))
			slot_enable_r <= (frame_sync || framed_r)
				&& (slot_nxt == slot_sel);
	end

	a_sync_clears: assert property (@(posedge clock) disable iff (!reset_n)
		bit_edge && frame_sync |=> bit_cnt_r == '0 && slot_cnt_r == '0)
		else $error("sync did not clear counters");
	a_slot_advance: assert property (@(posedge clock) disable iff (!reset_n)
		bit_edge && !frame_sync && bit_cnt_r == BIT_LAST
		|=> slot_cnt_r == $past(slot_cnt_r) + 6'h01)
		else $error("slot counter did not advance");
	a_enable_steady: assert property (@(posedge clock) disable iff (!reset_n)
		!(bit_edge && bit_cnt_r == BIT_LAST) && !(bit_edge && frame_sync)
		|=> $stable(slot_enable_r))
		else $error("enable moved off a word boundary");
	// Enable after a boundary must match the slot now counted
	a_enable_match: assert property (@(posedge clock) disable iff (!reset_n)
		bit_edge && (frame_sync || bit_cnt_r == BIT_LAST)
		|=> slot_enable_r == (framed_r && slot_cnt_r == $past(slot_sel)))
		else $error("enable not set for the selected slot");
	c_enable_rise: cover property (@(posedge clock) disable iff (!reset_n)
		$rose(slot_enable_r));
endmodule // slot_timer

// >>> core/pcm_time_slot_assigner.sv
// PCM time-slot assigner: link sampling, slot enables and AHB-Lite registers
`timescale 1ns/10ps
module pcm_time_slot_assigner
	import slot_assign_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        bit_rate_clock,
	input  wire logic        tx_frame_sync,
	input  wire logic        rx_frame_sync,
	output logic             tx_slot_enable,
	output logic             rx_slot_enable,
	output logic             channel_pulse,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	logic [2:0]        bclk_sync_r;
	logic [1:0]        txfs_sync_r;
	logic [1:0]        rxfs_sync_r;
	logic              bit_edge;
	logic [31:0]       ctrl_r;
	logic [SLOT_W-1:0] slot_held_r;
	logic              swap_held_r;
	logic [SLOT_W-1:0] slot_active;
	logic              swap_active;
	logic              en_a;
	logic              en_b;
	logic [SLOT_W-1:0] cnt_a;
	logic [SLOT_W-1:0] cnt_b;
	logic              tx_nxt;
	logic              rx_nxt;
	logic              wr_pend_r;
	logic [ADDR_W-1:0] wr_addr_r;
	logic              addr_ok;
	logic [31:0]       status;

	// Two flops before use; the third only feeds the edge detector
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bclk_sync_r <= '0;
			txfs_sync_r <= '0;
			rxfs_sync_r <= '0;
		end
		else
		begin
			bclk_sync_r <= {bclk_sync_r[1:0], bit_rate_clock};
			txfs_sync_r <= {txfs_sync_r[0], tx_frame_sync};
			rxfs_sync_r <= {rxfs_sync_r[0], rx_frame_sync};
		end
	end

	// Leading edge of the bit clock; syncs share its two-flop delay
	assign bit_edge = bclk_sync_r[1] & ~bclk_sync_r[2];

	// Slot word hold: transparent while hold is high
	assign slot_active = ctrl_r[CTRL_HOLD_BIT] ?
		ctrl_r[CTRL_SLOT_LSB +: SLOT_W] : slot_held_r;
	assign swap_active = ctrl_r[CTRL_HOLD_BIT] ?
		ctrl_r[CTRL_SWAP_BIT] : swap_held_r;

	// Capture on every cycle of hold high, keep once it drops
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			slot_held_r <= '0;
			swap_held_r <= 1'b1;
		end
		else if (ctrl_r[CTRL_HOLD_BIT])
		begin
			slot_held_r <= ctrl_r[CTRL_SLOT_LSB +: SLOT_W];
			swap_held_r <= ctrl_r[CTRL_SWAP_BIT];
		end
	end

	// Timer a follows the transmit sync, timer b the receive sync
	slot_timer u_timer_a (
		.clock         (clock),
		.reset_n       (reset_n),
		.bit_edge      (bit_edge),
		.frame_sync    (txfs_sync_r[1]),
		.slot_sel      (slot_active),
		.slot_enable_r (en_a),
		.slot_cnt_r    (cnt_a)
	);

	slot_timer u_timer_b (
		.clock         (clock),
		.reset_n       (reset_n),
		.bit_edge      (bit_edge),
		.frame_sync    (rxfs_sync_r[1]),
		.slot_sel      (slot_active),
		.slot_enable_r (en_b),
		.slot_cnt_r    (cnt_b)
	);

	// Swap routing of the two timers onto the enables
	assign tx_nxt = swap_active ? en_a : en_b;
	assign rx_nxt = swap_active ? en_b : en_a;

	// Outputs registered; one cycle behind the timers
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_slot_enable <= 1'b0;
			rx_slot_enable <= 1'b0;
			channel_pulse  <= 1'b0;
		end
		else
		begin
			tx_slot_enable <= tx_nxt;
			rx_slot_enable <= rx_nxt;
			channel_pulse  <= ctrl_r[CTRL_GATE_BIT] & tx_nxt;
		end
	end

	// Bus slave: zero wait states, always OKAY
	assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ
		&& hsize == HSIZE_WORD;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Write address held for the data phase
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
		end
		else
		begin
			wr_pend_r <= addr_ok && hwrite;
			wr_addr_r <= haddr[ADDR_W-1:0];
		end
	end

	// Control register; reset leaves swap, hold and gate high
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			ctrl_r <= CTRL_RESET;
		else if (wr_pend_r && wr_addr_r == CTRL_OFS)
			ctrl_r <= hwdata & 32'h0000_073f;
	end

	// Status shows live counters and outputs
	always_comb
	begin
		status = '0;
		status[CTRL_SLOT_LSB +: SLOT_W]  = slot_active;
		status[STAT_TXCNT_LSB +: SLOT_W] = cnt_a;
		status[STAT_RXCNT_LSB +: SLOT_W] = cnt_b;
		status[STAT_TXEN_BIT]  = tx_slot_enable;
		status[STAT_RXEN_BIT]  = rx_slot_enable;
		status[STAT_PULSE_BIT] = channel_pulse;
		status[STAT_SWAP_BIT]  = swap_active;
	end

	// Read data set up in the address phase; unmapped reads zero
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			hrdata <= '0;
		else if (addr_ok && !hwrite)
		begin
			if (haddr[ADDR_W-1:0] == CTRL_OFS)
				hrdata <= ctrl_r;
			else if (haddr[ADDR_W-1:0] == STATUS_OFS)
				hrdata <= status;
			else
				hrdata <= '0;
		end
	end

	a_swap_route: assert property (@(posedge clock) disable iff (!reset_n)
		1'b1 |=> tx_slot_enable == ($past(swap_active) ? $past(en_a)
		: $past(en_b)) && rx_slot_enable == ($past(swap_active)
		? $past(en_b) : $past(en_a)))
		else $error("enables routed wrongly");
	a_pulse_gated: assert property (@(posedge clock) disable iff (!reset_n)
		1'b1 |=> channel_pulse == ($past(ctrl_r[CTRL_GATE_BIT])
		&& $past(tx_nxt)))
		else $error("channel pulse not gate and transmit slot");
	a_pulse_in_slot: assert property (@(posedge clock) disable iff (!reset_n)
		channel_pulse |-> tx_slot_enable)
		else $error("channel pulse outside transmit slot");
	a_hold_keeps: assert property (@(posedge clock) disable iff (!reset_n)
		!ctrl_r[CTRL_HOLD_BIT] ##1 !ctrl_r[CTRL_HOLD_BIT]
		|-> $stable(slot_active) && $stable(swap_active))
		else $error("held slot word changed");
	a_edge_single: assert property (@(posedge clock) disable iff (!reset_n)
		bit_edge |=> !bit_edge [*2])
		else $error("bit edge seen on adjacent cycles");
	a_bus_okay: assert property (@(posedge clock) disable iff (!reset_n)
		hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	c_tx_slot: cover property (@(posedge clock) disable iff (!reset_n)
		$fell(tx_slot_enable));
	c_pulse: cover property (@(posedge clock) disable iff (!reset_n)
		$rose(channel_pulse));
	c_swapped: cover property (@(posedge clock) disable iff (!reset_n)
		!swap_active && rx_slot_enable);
	c_held: cover property (@(posedge clock) disable iff (!reset_n)
		$fell(ctrl_r[CTRL_HOLD_BIT]));
endmodule // pcm_time_slot_assigner

// >>> tb/highway_timing.sv
// Highway timing model: free-running bit clock and two frame syncs
`timescale 1ns/10ps
module highway_timing
(
	input  wire logic       sync_on,
	input  wire logic [8:0] rx_offset,
	output logic            bit_rate_clock,
	output logic            tx_frame_sync,
	output logic            rx_frame_sync
);
	logic [8:0] bit_idx = 9'h000;
	logic       bclk_q  = 1'b0;
	logic       txfs_q  = 1'b0;
	logic       rxfs_q  = 1'b0;

	// Bit clock of 400 ns, inside the highest allowed rate
	always #200 bclk_q = ~bclk_q;

	// Syncs move on the falling edge so each spans one leading edge;
	// held off until the bench lets framing start
	always @(negedge bclk_q)
	begin
		txfs_q  <= sync_on && (bit_idx == 9'h000);
		rxfs_q  <= sync_on && (bit_idx == rx_offset);
		bit_idx <= bit_idx + 9'h001;
	end

	// One driver per output pin
	assign bit_rate_clock = bclk_q;
	assign tx_frame_sync  = txfs_q;
	assign rx_frame_sync  = rxfs_q;
endmodule // highway_timing

// >>> tb/tb_top.sv
// Self-checking bench for the PCM time-slot assigner
`timescale 1ns/10ps
module tb_top
	import slot_assign_pkg::*;
;
	typedef struct packed {
		logic [5:0]  slot;
		logic        sw;
		logic        gate;
		logic [8:0]  ofs;
		logic [31:0] up;
	} row_t;

	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic [8:0]  rx_offset = 9'h000;
	logic        sw = 1'b1;
	logic        sync_on = 1'b0;
	logic        bit_rate_clock, tx_frame_sync, rx_frame_sync;
	logic        tx_slot_enable, rx_slot_enable, channel_pulse;
	logic        hreadyout, hresp;
	logic [31:0] hrdata, ct, cr, tx_up, tx_dn, rx_up, rx_dn, cp_up, q;
	logic [31:0] tx_n = 0, rx_n = 0, cp_n = 0, checks = 0, mismatches = 0;
	wire         hready = hreadyout;
	row_t        rows [4] = '{
		'{6'h00, 1'b1, 1'b1, 9'h000, 32'h000},
		'{6'h05, 1'b1, 1'b0, 9'h008, 32'h028},
		'{6'h3f, 1'b0, 1'b1, 9'h064, 32'h1f8},
		'{6'h21, 1'b0, 1'b1, 9'h12c, 32'h108}
	};

	pcm_time_slot_assigner i_pcm_time_slot_assigner (
		.clock          (clock),
		.reset_n        (reset_n),
		.bit_rate_clock (bit_rate_clock),
		.tx_frame_sync  (tx_frame_sync),
		.rx_frame_sync  (rx_frame_sync),
		.tx_slot_enable (tx_slot_enable),
		.rx_slot_enable (rx_slot_enable),
		.channel_pulse  (channel_pulse),
		.hsel           (hsel),
		.haddr          (haddr),
		.htrans         (htrans),
		.hwrite         (hwrite),
		.hsize          (hsize),
		.hwdata         (hwdata),
		.hready         (hready),
		.hreadyout      (hreadyout),
		.hresp          (hresp),
		.hrdata         (hrdata)
	);
	highway_timing i_highway_timing (
		.sync_on        (sync_on),
		.rx_offset      (rx_offset),
		.bit_rate_clock (bit_rate_clock),
		.tx_frame_sync  (tx_frame_sync),
		.rx_frame_sync  (rx_frame_sync)
	);

	always #25 clock = ~clock;

	// Bit counts since each sync, taken on the leading edge
	always @(posedge bit_rate_clock)
	begin
		ct <= tx_frame_sync ? 32'h0 : ct + 32'h1;
		cr <= rx_frame_sync ? 32'h0 : cr + 32'h1;
	end
	// Edge positions against the sync that should time each output
	always @(posedge tx_slot_enable)
	begin
		tx_up = sw ? ct : cr;
		tx_n++;
	end
	always @(negedge tx_slot_enable) tx_dn = sw ? ct : cr;
	always @(posedge rx_slot_enable)
	begin
		rx_up = sw ? cr : ct;
		rx_n++;
	end
	always @(negedge rx_slot_enable) rx_dn = sw ? cr : ct;
	always @(posedge channel_pulse)
	begin
		cp_up = sw ? ct : cr;
		cp_n++;
	end

	task automatic chk(input string what, input logic [31:0] exp, seen);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Waits for hready at an edge; the watchdog ends a stuck wait
	task automatic ready_edge;
		@(posedge clock);
		while (hready !== 1'b1)
			@(posedge clock);
	endtask

	// One single word transfer, entered just after a rising edge
	task automatic ahb(input logic wr, input logic [31:0] a, d,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		ready_edge();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		ready_edge();
		rd = hrdata;
	endtask

	// Settle two frames, then count over exactly one frame
	task automatic frame;
		repeat (8400) @(posedge clock);
		@(negedge clock);
		tx_n = 0;
		rx_n = 0;
		cp_n = 0;
		repeat (4096) @(negedge clock);
		@(posedge clock);
	endtask

	initial
	begin
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		ahb(1'b0, 32'h0, 32'h0, q);
		chk("ctrl reset", 32'h0000_0700, q);
		ahb(1'b1, 32'h8, 32'hffff_ffff, q);
		ahb(1'b0, 32'h8, 32'h0, q);
		chk("unmapped", 32'h0, q);
		ahb(1'b0, 32'h0, 32'h0, q);
		chk("ctrl kept", 32'h0000_0700, q);
		ahb(1'b0, 32'h4, 32'h0, q);
		chk("no sync yet", 32'h0, {30'h0, q[25:24]});
		// Framing starts only after the unsynced check
		sync_on <= 1'b1;
		foreach (rows[i])
		begin
			sw = rows[i].sw;
			rx_offset <= rows[i].ofs;
			ahb(1'b1, 32'h0, {21'h0, rows[i].gate, 1'b1, rows[i].sw,
				2'h0, rows[i].slot}, q);
			frame();
			chk("tx rise", rows[i].up, tx_up);
			chk("tx fall", (rows[i].up + 32'h8) % 32'd512, tx_dn);
			chk("rx rise", rows[i].up, rx_up);
			chk("rx fall", (rows[i].up + 32'h8) % 32'd512, rx_dn);
			chk("tx count", 32'h1, tx_n);
			chk("rx count", 32'h1, rx_n);
			chk("pulse count", {31'h0, rows[i].gate}, cp_n);
			if (rows[i].gate)
				chk("pulse slot", rows[i].up, cp_up);
		end
		// Hold low must keep slot 33 and swap low from the last row;
		// hold is dropped on the channel's own pulse
		@(posedge channel_pulse);
		@(posedge clock);
		ahb(1'b1, 32'h0, 32'h0000_0507, q);
		frame();
		chk("held slot", 32'h108, tx_up);
		ahb(1'b0, 32'h4, 32'h0, q);
		chk("held word", 32'h21, {25'h0, q[27], q[5:0]});
		ahb(1'b1, 32'h0, 32'h0000_0707, q);
		ahb(1'b0, 32'h4, 32'h0, q);
		chk("open word", 32'h47, {25'h0, q[27], q[5:0]});
		// Reset in mid-run clears the enables and returns the control word to its reset value
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		chk("reset enables", 32'h0, {30'h0, tx_slot_enable,
			rx_slot_enable});
		reset_n <= 1'b1;
		@(posedge clock);
		ahb(1'b0, 32'h0, 32'h0, q);
		chk("ctrl after reset", 32'h0000_0700, q);
		stop_test();
	end

	// Cut a hang short well past the expected run length
	initial
	begin
		repeat (90000) @(posedge clock);
		mismatches++;
		stop_test();
	end
endmodule // tb_top
